// [design/dmac_gate_pkg.sv]
// Constants shared by the DMA controller security gate.
package dmac_gate_pkg;

	// ************************************************************
	// Register map (byte addresses, one word each)
	// ************************************************************
	localparam logic [11:0] ADDR_LAUNCH   = 12'h0000;
	localparam logic [11:0] ADDR_START    = 12'h0004;
	localparam logic [11:0] ADDR_STATUS   = 12'h0008;
	localparam logic [11:0] ADDR_CHAN_SEC = 12'h000C;
	localparam logic [11:0] ADDR_ABORTS   = 12'h0010;
	localparam logic [11:0] ADDR_LAUNCHED = 12'h0014;
	localparam logic [11:0] ADDR_IRQ_SEC  = 12'h0018;
	localparam logic [11:0] ADDR_PER_SEC  = 12'h001C;
	localparam logic [11:0] ADDR_LAST_LNC = 12'h0020;

	// ************************************************************
	// Field layout of the launch word
	// ************************************************************
	localparam int LAUNCH_CHAN_LSB = 0;
	localparam int LAUNCH_NS_BIT   = 8;

	// ************************************************************
	// Launch outcomes
	// ************************************************************
	typedef enum logic [1:0]
	{
		OUT_NONE,
		OUT_OK,
		OUT_NOP,
		OUT_ABORT
	} outcome_e;

	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

endpackage

// [design/dmac_access_check.sv]
// Per-channel security check of instruction fetches and data accesses.
`timescale 1ns/1ns
`default_nettype none

module dmac_access_check #(
	parameter int CHANNELS = 8
)
(
	input  wire logic                chan_nonsecure_i,
	input  wire logic                acc_valid_i,
	input  wire logic                acc_secure_addr_i,
	input  wire logic                acc_fetch_i,
	input  wire logic                bus_abort_i,
	output logic                     allow_o,
	output logic                     fetch_fault_o,
	output logic                     data_fault_o
);

	logic fault;

	always_comb
	begin
		// Secure channels reach everything, non-secure only open memory.
		allow_o = acc_valid_i && !(chan_nonsecure_i && acc_secure_addr_i);
		fault = acc_valid_i && (bus_abort_i || (chan_nonsecure_i && acc_secure_addr_i));
		fetch_fault_o = fault && acc_fetch_i;
		data_fault_o  = fault && !acc_fetch_i;
	end

endmodule
`default_nettype wire

// [design/dmac_security_gate.sv]
// Security gate in front of a multi-channel DMA controller.
`timescale 1ns/1ns
`default_nettype none

module dmac_security_gate #(
	parameter int CHANNELS = 8,
	parameter int EVENTS   = 16,
	parameter int PERIPHS  = 4
)
(
	input  wire logic                mclk_i,
	input  wire logic                arst_n_i,
	input  wire logic                clk_en_i,
	input  wire logic                core_reset_i,
	input  wire logic                manager_world_input_i,
	input  wire logic [EVENTS-1:0]   irq_world_inputs_i,
	input  wire logic [PERIPHS-1:0]  periph_world_inputs_i,
	input  wire logic                s_psel_i,
	input  wire logic                s_penable_i,
	input  wire logic                s_pwrite_i,
	input  wire logic [11:0]         s_paddr_i,
	input  wire logic [31:0]         s_pwdata_i,
	input  wire logic [2:0]          s_pprot_i,
	output logic                     s_pready_o,
	output logic                     s_pslverr_o,
	output logic [31:0]              s_prdata_o,
	input  wire logic                n_psel_i,
	input  wire logic                n_penable_i,
	input  wire logic                n_pwrite_i,
	input  wire logic [11:0]         n_paddr_i,
	input  wire logic [31:0]         n_pwdata_i,
	input  wire logic [2:0]          n_pprot_i,
	output logic                     n_pready_o,
	output logic                     n_pslverr_o,
	output logic [31:0]              n_prdata_o,
	input  wire logic [CHANNELS-1:0] acc_valid_i,
	input  wire logic [CHANNELS-1:0] acc_fetch_i,
	input  wire logic [CHANNELS-1:0] acc_secure_addr_i,
	input  wire logic [CHANNELS-1:0] bus_abort_i,
	output logic [CHANNELS-1:0]      acc_allow_o,
	output logic [CHANNELS-1:0]      acc_nonsecure_o,
	output logic [CHANNELS-1:0]      chan_active_o,
	output logic [31:0]              chan_start_addr_o,
	output logic [$clog2(CHANNELS)-1:0] chan_start_num_o,
	output logic                     chan_start_o,
	output logic                     fault_irq_o,
	input  wire logic [EVENTS-1:0]   event_req_i,
	input  wire logic [EVENTS-1:0]   event_req_ns_i,
	output logic [EVENTS-1:0]        event_allow_o,
	input  wire logic [CHANNELS-1:0] wait_req_i,
	input  wire logic [CHANNELS-1:0] wait_evt_i,
	output logic [CHANNELS-1:0]      wait_allow_o,
	input  wire logic [PERIPHS-1:0]  periph_req_i,
	input  wire logic [PERIPHS-1:0]  periph_req_ns_i,
	output logic [PERIPHS-1:0]       periph_allow_o,
	output logic                     dmac_world_select_o
);

	localparam int CW = $clog2(CHANNELS);

	initial
	begin
		if (CHANNELS < 2 || CHANNELS > 32 || EVENTS < 1 || EVENTS > 32
			|| PERIPHS < 1 || PERIPHS > 32)
			$error("dmac_security_gate: unsupported parameter value");
	end

	// ************************************************************
	// Security holding registers
	// ************************************************************
	// These are caught on the first enabled edge after core reset leaves,
	// so a core reset never disturbs them while it is held.
	logic               world_q, world_d;
	logic [EVENTS-1:0]  irq_world_q, irq_world_d;
	logic [PERIPHS-1:0] per_world_q, per_world_d;
	logic               armed_q, armed_d;

	always_comb
	begin
		world_d     = world_q;
		irq_world_d = irq_world_q;
		per_world_d = per_world_q;
		armed_d     = armed_q;
		if (core_reset_i)
			armed_d = 1'b0;
		else if (!armed_q)
		begin
			world_d     = manager_world_input_i;
			irq_world_d = irq_world_inputs_i;
			per_world_d = periph_world_inputs_i;
			armed_d     = 1'b1;
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			world_q     <= 1'b0;
			irq_world_q <= '0;
			per_world_q <= '0;
			armed_q     <= 1'b0;
		end
		else if (clk_en_i)
		begin
			world_q     <= world_d;
			irq_world_q <= irq_world_d;
			per_world_q <= per_world_d;
			armed_q     <= armed_d;
		end
	end

	// ************************************************************
	// Launch decision
	// ************************************************************
	// pprot[1] high marks a non-secure master. Both ports answer with
	// no wait states; the secure port has priority if both write at once.
	logic s_acc, n_acc, s_wr, n_wr, s_bad, n_bad;
	logic launch, launch_ns, launch_nop, launch_abort;
	logic [31:0] lw;
	logic [CW-1:0] lchan;
	dmac_gate_pkg::outcome_e outcome;

	always_comb
	begin
		s_acc = s_psel_i && s_penable_i && armed_q && !core_reset_i;
		n_acc = n_psel_i && n_penable_i && armed_q && !core_reset_i;
		s_wr  = s_acc && s_pwrite_i;
		n_wr  = n_acc && n_pwrite_i && !s_wr;
		s_bad = s_acc && s_pprot_i[1];
		n_bad = n_wr && !world_q;
		lw    = s_wr ? s_pwdata_i : n_pwdata_i;
		lchan = lw[dmac_gate_pkg::LAUNCH_CHAN_LSB +: CW];
		launch = 1'b0;
		launch_ns = 1'b1;
		launch_nop = 1'b0;
		launch_abort = 1'b0;
		if (s_wr && !s_bad && s_paddr_i == dmac_gate_pkg::ADDR_LAUNCH)
		begin
			if (!world_q)
			begin
				launch    = 1'b1;
				launch_ns = lw[dmac_gate_pkg::LAUNCH_NS_BIT];
			end
			else if (!lw[dmac_gate_pkg::LAUNCH_NS_BIT])
				launch_nop = 1'b1;
			else
				launch = 1'b1;
		end
		else if (n_wr && !n_bad && n_paddr_i == dmac_gate_pkg::ADDR_LAUNCH)
			launch = 1'b1;
		else if (n_bad)
			launch_abort = 1'b1;
		if (launch)
			outcome = dmac_gate_pkg::OUT_OK;
		else if (launch_nop)
			outcome = dmac_gate_pkg::OUT_NOP;
		else if (launch_abort)
			outcome = dmac_gate_pkg::OUT_ABORT;
		else
			outcome = dmac_gate_pkg::OUT_NONE;
	end

	// ************************************************************
	// Channel state and start address
	// ************************************************************
	logic [CHANNELS-1:0] active_q, active_d, cns_q, cns_d, abort_q, abort_d;
	logic [CHANNELS-1:0] fetch_f, data_f;
	logic [31:0] addr_q, addr_d, last_q, last_d;
	logic [CW-1:0] num_q, num_d;
	logic start_q, start_d, irq_q, irq_d;
	logic [1:0] outcome_q, outcome_d;

	always_comb
	begin
		active_d  = active_q;
		cns_d     = cns_q;
		abort_d   = abort_q | fetch_f | data_f;
		addr_d    = addr_q;
		last_d    = last_q;
		num_d     = num_q;
		start_d   = 1'b0;
		outcome_d = outcome_q;
		if (outcome != dmac_gate_pkg::OUT_NONE)
			outcome_d = outcome;
		if (s_wr && !s_bad && s_paddr_i == dmac_gate_pkg::ADDR_START)
			addr_d = s_pwdata_i;
		else if (n_wr && !n_bad && n_paddr_i == dmac_gate_pkg::ADDR_START)
			addr_d = n_pwdata_i;
		if (launch)
		begin
			active_d[lchan] = 1'b1;
			cns_d[lchan]    = launch_ns;
			// A fault seen in the launch cycle still wins over the clear.
			abort_d[lchan]  = fetch_f[lchan] | data_f[lchan];
			num_d           = lchan;
			last_d          = lw;
			start_d         = 1'b1;
		end
		irq_d = |(abort_d);
		if (core_reset_i)
		begin
			active_d  = '0;
			cns_d     = '0;
			abort_d   = '0;
			irq_d     = 1'b0;
			start_d   = 1'b0;
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			active_q  <= '0;
			cns_q     <= '0;
			abort_q   <= '0;
			addr_q    <= dmac_gate_pkg::RESET_WORD;
			last_q    <= dmac_gate_pkg::RESET_WORD;
			num_q     <= '0;
			start_q   <= 1'b0;
			irq_q     <= 1'b0;
			outcome_q <= 2'b00;
		end
		else if (clk_en_i)
		begin
			active_q  <= active_d;
			cns_q     <= cns_d;
			abort_q   <= abort_d;
			addr_q    <= addr_d;
			last_q    <= last_d;
			num_q     <= num_d;
			start_q   <= start_d;
			irq_q     <= irq_d;
			outcome_q <= outcome_d;
		end
	end

	// ************************************************************
	// Access checks, one per channel
	// ************************************************************
	// Only channel security decides memory access; the interrupt and
	// peripheral world bits are never consulted here.
	for (genvar c = 0; c < CHANNELS; c++)
	begin : g_chk
		dmac_access_check #(.CHANNELS(CHANNELS)) u_chk
		(
			.chan_nonsecure_i  (cns_q[c]),
			.acc_valid_i       (acc_valid_i[c] && active_q[c]),
			.acc_secure_addr_i (acc_secure_addr_i[c]),
			.acc_fetch_i       (acc_fetch_i[c]),
			.bus_abort_i       (bus_abort_i[c]),
			.allow_o           (acc_allow_o[c]),
			.fetch_fault_o     (fetch_f[c]),
			.data_fault_o      (data_f[c])
		);
	end

	// ************************************************************
	// Interrupt, wait and peripheral gating
	// ************************************************************
	always_comb
	begin
		// A non-secure request may only touch a line marked non-secure.
		event_allow_o  = event_req_i & (~event_req_ns_i | irq_world_q);
		wait_allow_o   = '0;
		for (int c = 0; c < CHANNELS; c++)
			wait_allow_o[c] = wait_req_i[c] && active_q[c]
				&& (!cns_q[c] || irq_world_q[wait_evt_i[c] ? c % EVENTS : 0]);
		periph_allow_o = periph_req_i & (~periph_req_ns_i | per_world_q);
	end

	// ************************************************************
	// Read data
	// ************************************************************
	function automatic logic [31:0] rd(input logic [11:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (a)
			dmac_gate_pkg::ADDR_STATUS:   v = {28'h000_0000, outcome_q, armed_q, world_q};
			dmac_gate_pkg::ADDR_START:    v = addr_q;
			dmac_gate_pkg::ADDR_CHAN_SEC: v = 32'(cns_q);
			dmac_gate_pkg::ADDR_ABORTS:   v = 32'(abort_q);
			dmac_gate_pkg::ADDR_LAUNCHED: v = 32'(active_q);
			dmac_gate_pkg::ADDR_IRQ_SEC:  v = 32'(irq_world_q);
			dmac_gate_pkg::ADDR_PER_SEC:  v = 32'(per_world_q);
			dmac_gate_pkg::ADDR_LAST_LNC: v = last_q;
			default:                      v = 32'h0000_0000;
		endcase
		return v;
	endfunction

	always_comb
	begin
		s_pready_o  = 1'b1;
		n_pready_o  = 1'b1;
		s_pslverr_o = s_acc && s_bad;
		n_pslverr_o = n_acc && n_pwrite_i && !world_q;
		s_prdata_o  = (s_acc && !s_bad) ? rd(s_paddr_i) : 32'h0000_0000;
		n_prdata_o  = n_acc ? rd(n_paddr_i) : 32'h0000_0000;
	end

	assign acc_nonsecure_o     = cns_q;
	assign chan_active_o       = active_q;
	assign chan_start_addr_o   = addr_q;
	assign chan_start_num_o    = num_q;
	assign chan_start_o        = start_q;
	assign fault_irq_o         = irq_q;
	assign dmac_world_select_o = world_q;

endmodule
`default_nettype wire

// [test/dmac_gate_checker.sv]
// Concurrent checks on the ports of the DMA controller security gate.
`timescale 1ns/1ns
`default_nettype none

module dmac_gate_checker #(
	parameter int CHANNELS = 8
)
(
	input wire logic	mclk_i,
	input wire logic	arst_n_i,
	input wire logic	clk_en_i,
	input wire logic	core_reset_i,
	input wire logic	s_psel_i,
	input wire logic	s_penable_i,
	input wire logic	s_pwrite_i,
	input wire logic [2:0]	s_pprot_i,
	input wire logic	s_pslverr_o,
	input wire logic [31:0]	s_prdata_o,
	input wire logic	n_psel_i,
	input wire logic	n_penable_i,
	input wire logic	n_pwrite_i,
	input wire logic	n_pslverr_o,
	input wire logic [CHANNELS-1:0]	acc_valid_i,
	input wire logic [CHANNELS-1:0]	acc_secure_addr_i,
	input wire logic [CHANNELS-1:0]	bus_abort_i,
	input wire logic [CHANNELS-1:0]	acc_allow_o,
	input wire logic [CHANNELS-1:0]	acc_nonsecure_o,
	input wire logic [CHANNELS-1:0]	chan_active_o,
	input wire logic	chan_start_o,
	input wire logic	fault_irq_o,
	input wire logic	dmac_world_select_o
);
	logic [1:0]	age_q;
	logic [1:0]	age_d;
	logic	busy;
	logic	fault;
	// A frozen clock enable holds every register, so no change is judged.
	assign busy = s_psel_i & s_pwrite_i | n_psel_i & n_pwrite_i | core_reset_i
		| !clk_en_i;
	assign fault = |(acc_valid_i & chan_active_o &
		(bus_abort_i | acc_nonsecure_o & acc_secure_addr_i));
	// Edges since a reset; the latching edge itself is never judged.
	always_comb
	begin
		age_d = age_q + {1'b0, age_q != 2'd2};
		if (core_reset_i)
			age_d = 2'd0;
	end
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			age_q <= 2'd0;
		else
			age_q <= age_d;
	end
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (!arst_n_i);
	a_refuse_open_master: assert property (age_q == 2'd2 && s_psel_i &&
		s_penable_i && s_pprot_i[1] |-> s_pslverr_o && s_prdata_o == '0)
		else $error("secure port served an open master");
	a_abort_open_port: assert property (age_q == 2'd2 && n_psel_i &&
		n_penable_i && n_pwrite_i && !dmac_world_select_o |-> n_pslverr_o)
		else $error("open port write not aborted");
	a_world_frozen: assert property (age_q == 2'd2 && !core_reset_i
		|-> $stable(dmac_world_select_o))
		else $error("world changed after latching");
	a_open_world_ns: assert property (dmac_world_select_o |->
		(chan_active_o & ~acc_nonsecure_o) == '0)
		else $error("secure channel live in open world");
	a_access_gate: assert property (acc_allow_o == (acc_valid_i &
		chan_active_o & ~(acc_nonsecure_o & acc_secure_addr_i)))
		else $error("access permission wrong");
	a_fault_raises: assert property (fault && !busy |=> fault_irq_o)
		else $error("fault did not raise the interrupt");
	a_fault_sticky: assert property (fault_irq_o && !busy |=> fault_irq_o)
		else $error("fault interrupt dropped");
	a_core_clears: assert property (core_reset_i && clk_en_i |=>
		chan_active_o == '0 && !fault_irq_o)
		else $error("core reset left channels set");
	c_launch: cover property (chan_start_o);
	c_fault: cover property ($rose(fault_irq_o));
	c_abort: cover property (n_pslverr_o);
endmodule

bind dmac_security_gate dmac_gate_checker #(.CHANNELS(CHANNELS)) gate_chk (
	.mclk_i, .arst_n_i, .clk_en_i, .core_reset_i, .s_psel_i, .s_penable_i,
	.s_pwrite_i, .s_pprot_i, .s_pslverr_o, .s_prdata_o, .n_psel_i,
	.n_penable_i,
	.n_pwrite_i, .n_pslverr_o, .acc_valid_i, .acc_secure_addr_i, .bus_abort_i,
	.acc_allow_o, .acc_nonsecure_o, .chan_active_o, .chan_start_o,
	.fault_irq_o, .dmac_world_select_o
);
`default_nettype wire

// [test/apb_core_model.sv]
// Processor core model issuing APB transfers on one configuration port.
`timescale 1ns/1ns
`default_nettype none

module apb_core_model
(
	input wire logic	clk_i,
	input wire logic	pready_i,
	input wire logic	pslverr_i,
	input wire logic [31:0]	prdata_i,
	output logic	psel_o,
	output logic	penable_o,
	output logic	pwrite_o,
	output logic [11:0]	paddr_o,
	output logic [31:0]	pwdata_o,
	output logic [2:0]	pprot_o
);
	initial
	begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 12'h000;
		pwdata_o = 32'h0000_0000;
		pprot_o = 3'h0;
	end
	task automatic xfer(input logic wr, input logic [11:0] a,
		input logic [31:0] d, input logic nsm,
		output logic [31:0] rd, output logic err);
		@(posedge clk_i);
		psel_o <= 1'b1;
		pwrite_o <= wr;
		paddr_o <= a;
		pwdata_o <= d;
		pprot_o <= {1'b0, nsm, 1'b0};
		@(posedge clk_i);
		penable_o <= 1'b1;
		do
		begin
			@(posedge clk_i);
		end
		while (pready_i !== 1'b1);
		rd = prdata_i;
		err = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		// Released lines show inverted values so stale data cannot pass.
		pwdata_o <= ~d;
		paddr_o <= ~a;
	endtask
endmodule
`default_nettype wire

// [test/dmac_security_gate_bench.sv]
// Randomised self-checking bench for the DMA controller security gate.
`timescale 1ns/1ns
`default_nettype none

module dmac_security_gate_bench;
	localparam int CH = 8;
	localparam int EV = 16;
	localparam int PR = 4;
	logic	mclk_i = 1'b0;
	logic	arst_n_i = 1'b0;
	logic	core_reset_i = 1'b0;
	logic	clk_en_i = 1'b1;
	logic	manager_world_input_i = 1'b0;
	logic [EV-1:0]	irq_world_inputs_i = '0, event_req_i = '0, event_req_ns_i = '0;
	logic [PR-1:0]	periph_world_inputs_i = '0, periph_req_i = '0;
	logic [PR-1:0]	periph_req_ns_i = '0;
	logic [CH-1:0]	acc_valid_i = '0, acc_fetch_i = '0, acc_secure_addr_i = '0;
	logic [CH-1:0]	bus_abort_i = '0, wait_req_i = '0, wait_evt_i = '0;
	wire	s_psel_i, s_penable_i, s_pwrite_i, s_pready_o, s_pslverr_o;
	wire	n_psel_i, n_penable_i, n_pwrite_i, n_pready_o, n_pslverr_o;
	wire [11:0]	s_paddr_i, n_paddr_i;
	wire [31:0]	s_pwdata_i, n_pwdata_i, s_prdata_o, n_prdata_o;
	wire [2:0]	s_pprot_i, n_pprot_i, chan_start_num_o;
	wire [CH-1:0]	acc_allow_o, acc_nonsecure_o, chan_active_o, wait_allow_o;
	wire [31:0]	chan_start_addr_o;
	wire	chan_start_o, fault_irq_o, dmac_world_select_o;
	wire [EV-1:0]	event_allow_o;
	wire [PR-1:0]	periph_allow_o;
	logic [31:0]	rdat;
	logic	err;
	int	num_errors = 0;
	int	tests_run = 0;
	int	cycles = 0;
	dmac_security_gate #(.CHANNELS(CH), .EVENTS(EV), .PERIPHS(PR)) dut (
		.mclk_i, .arst_n_i, .clk_en_i, .core_reset_i,
		.manager_world_input_i, .irq_world_inputs_i, .periph_world_inputs_i,
		.s_psel_i, .s_penable_i, .s_pwrite_i, .s_paddr_i, .s_pwdata_i,
		.s_pprot_i, .s_pready_o, .s_pslverr_o, .s_prdata_o,
		.n_psel_i, .n_penable_i, .n_pwrite_i, .n_paddr_i, .n_pwdata_i,
		.n_pprot_i, .n_pready_o, .n_pslverr_o, .n_prdata_o,
		.acc_valid_i, .acc_fetch_i, .acc_secure_addr_i, .bus_abort_i,
		.acc_allow_o, .acc_nonsecure_o, .chan_active_o, .chan_start_addr_o,
		.chan_start_num_o, .chan_start_o, .fault_irq_o, .event_req_i,
		.event_req_ns_i, .event_allow_o, .wait_req_i, .wait_evt_i,
		.wait_allow_o, .periph_req_i, .periph_req_ns_i, .periph_allow_o,
		.dmac_world_select_o);
	apb_core_model s_core (.clk_i(mclk_i), .pready_i(s_pready_o),
		.pslverr_i(s_pslverr_o), .prdata_i(s_prdata_o), .psel_o(s_psel_i),
		.penable_o(s_penable_i), .pwrite_o(s_pwrite_i), .paddr_o(s_paddr_i),
		.pwdata_o(s_pwdata_i), .pprot_o(s_pprot_i));
	apb_core_model n_core (.clk_i(mclk_i), .pready_i(n_pready_o),
		.pslverr_i(n_pslverr_o), .prdata_i(n_prdata_o), .psel_o(n_psel_i),
		.penable_o(n_penable_i), .pwrite_o(n_pwrite_i), .paddr_o(n_paddr_i),
		.pwdata_o(n_pwdata_i), .pprot_o(n_pprot_i));
	always #5 mclk_i = ~mclk_i;
	task automatic tally_and_finish();
		$display("errors %0d of %0d checks", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge mclk_i)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic np, input logic wr, input logic [11:0] a,
		input logic [31:0] d, input logic nsm);
		if (np)
			n_core.xfer(wr, a, d, nsm, rdat, err);
		else
			s_core.xfer(wr, a, d, nsm, rdat, err);
	endtask
	// An open world or the open port forces an open channel.
	function automatic logic exp_ns(input logic w, np, f);
		return w | np | f;
	endfunction
	// A secure channel may always wait; an open one needs its line open.
	function automatic logic [CH-1:0] exp_wait(input logic [CH-1:0] r, e, ac,
		ns, input logic [EV-1:0] il);
		logic [CH-1:0] v;
		v = '0;
		for (int c = 0; c < CH; c++)
			v[c] = r[c] & ac[c] & (!ns[c] | il[e[c] ? c % EV : 0]);
		return v;
	endfunction
	initial
	begin
		logic [CH-1:0] act, nsv;
		logic [EV-1:0] irq_l;
		logic [PR-1:0] per_l;
		logic [31:0] a;
		logic [2:0] ch;
		logic [CH-1:0] ab;
		logic np, nsm, f, nop;
		void'($urandom(32'h9685));
		repeat (16) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		for (int w = 0; w < 2; w++)
		begin
			core_reset_i <= 1'b1;
			manager_world_input_i <= w[0];
			irq_world_inputs_i <= EV'($urandom);
			periph_world_inputs_i <= PR'($urandom);
			@(posedge mclk_i);
			core_reset_i <= 1'b0;
			irq_l = irq_world_inputs_i;
			per_l = periph_world_inputs_i;
			act = '0;
			nsv = '0;
			ab = '0;
			repeat (3) @(posedge mclk_i);
			irq_world_inputs_i <= ~irq_l;
			periph_world_inputs_i <= ~per_l;
			chk(chan_active_o, act);
			chk(dmac_world_select_o, w[0]);
			bus(1'b0, 1'b0, dmac_gate_pkg::ADDR_IRQ_SEC, '0, 1'b0);
			chk(rdat, irq_l);
			bus(1'b0, 1'b0, dmac_gate_pkg::ADDR_PER_SEC, '0, 1'b0);
			chk(rdat, per_l);
			bus(1'b0, 1'b0, dmac_gate_pkg::ADDR_STATUS, '0, 1'b0);
			chk(rdat[1:0], {1'b1, w[0]});
			bus(1'b0, 1'b1, dmac_gate_pkg::ADDR_START, '1, 1'b1);
			chk(err, 1'b1);
			bus(1'b0, 1'b0, dmac_gate_pkg::ADDR_STATUS, '0, 1'b1);
			chk(rdat, '0);
			bus(1'b1, 1'b1, dmac_gate_pkg::ADDR_START, '0, 1'b0);
			chk(err, !w[0]);
			repeat (10)
			begin
				ch = 3'($urandom);
				f = 1'($urandom);
				np = w[0] & 1'($urandom);
				nsm = np & 1'($urandom);
				a = $urandom;
				nop = w[0] & !np & !f;
				bus(np, 1'b1, dmac_gate_pkg::ADDR_START, a, nsm);
				bus(np, 1'b1, dmac_gate_pkg::ADDR_LAUNCH, {23'h00_0000, f, 5'h00, ch},
					nsm);
				@(posedge mclk_i);
				if (!nop)
				begin
					act[ch] = 1'b1;
					nsv[ch] = exp_ns(w[0], np, f);
					chk(chan_start_num_o, ch);
					chk(chan_start_addr_o, a);
				end
				chk(chan_start_o, !nop);
				chk(chan_active_o, act);
				chk(acc_nonsecure_o, nsv);
				bus(1'b0, 1'b0, dmac_gate_pkg::ADDR_STATUS, '0, 1'b0);
				chk(rdat[3:2], nop ? dmac_gate_pkg::OUT_NOP : dmac_gate_pkg::OUT_OK);
			end
			bus(1'b1, 1'b0, dmac_gate_pkg::ADDR_LAUNCHED, '0, w[0]);
			chk(rdat, act);
			bus(1'b1, 1'b0, dmac_gate_pkg::ADDR_CHAN_SEC, '0, w[0]);
			chk(rdat, nsv);
			// A fault offered while the clock enable is low must leave no mark.
			clk_en_i <= 1'b0;
			acc_valid_i <= '1;
			acc_secure_addr_i <= '1;
			bus_abort_i <= '1;
			repeat (2) @(posedge mclk_i);
			clk_en_i <= 1'b1;
			acc_valid_i <= '0;
			chk(fault_irq_o, 1'b0);
			@(posedge mclk_i);
			chk(fault_irq_o, 1'b0);
			repeat (12)
			begin
				acc_valid_i <= CH'($urandom);
				acc_fetch_i <= CH'($urandom);
				acc_secure_addr_i <= CH'($urandom);
				bus_abort_i <= CH'($urandom & $urandom);
				event_req_i <= EV'($urandom);
				event_req_ns_i <= EV'($urandom);
				periph_req_i <= PR'($urandom);
				periph_req_ns_i <= PR'($urandom);
				wait_req_i <= CH'($urandom);
				wait_evt_i <= CH'($urandom);
				@(posedge mclk_i);
				acc_valid_i <= '0;
				chk(acc_allow_o, acc_valid_i & act & ~(nsv & acc_secure_addr_i));
				chk(event_allow_o, event_req_i & (~event_req_ns_i | irq_l));
				chk(periph_allow_o, periph_req_i & (~periph_req_ns_i | per_l));
				chk(wait_allow_o, exp_wait(wait_req_i, wait_evt_i, act, nsv, irq_l));
				ab |= acc_valid_i & act & (bus_abort_i | nsv & acc_secure_addr_i);
				@(posedge mclk_i);
				chk(fault_irq_o, |ab);
				chk(acc_nonsecure_o, nsv);
			end
			bus(1'b0, 1'b0, dmac_gate_pkg::ADDR_ABORTS, '0, 1'b0);
			chk(rdat, ab);
		end
		tally_and_finish();
	end
endmodule
`default_nettype wire
